// ===== common/awr_pkg.sv
package awr_pkg;

	// register byte offsets (chosen, no offsets are printed)
	localparam logic [7:0] OFF_WARMUP_CTRL = 8'h00;
	localparam logic [7:0] OFF_PRESENCE    = 8'h04;
	localparam logic [7:0] OFF_FORMAT      = 8'h08;
	localparam logic [7:0] OFF_IRQ_STATUS  = 8'h0c;
	localparam logic [7:0] OFF_IRQ_MASK    = 8'h10;
	localparam logic [7:0] OFF_RESULT_BASE = 8'h20;
	localparam int         NUM_RESULTS     = 24;
	localparam int         NUM_INPUTS      = 20;

	// warm-up control field positions
	localparam int BIT_DED_EN     = 0;
	localparam int BIT_SHR_EN     = 7;
	localparam int BIT_DED_RDY    = 8;
	localparam int BIT_SHR_RDY    = 15;
	localparam int BIT_DED_IEN    = 16;
	localparam int BIT_SHR_IEN    = 23;
	localparam int CNT_LSB        = 24;
	localparam int CNT_MSB        = 27;

	// warm-up counting: 2**code converter clocks, least code 4
	localparam logic [3:0] MIN_EXP  = 4'h4;
	localparam int         WCNT_W   = 16;

	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic [18:0] PRESENT_LOW_RST = 19'h7ffff;
	localparam logic        PRESENT_TOP_DEF = 1'b1;

	// irq status bits
	localparam int IRQ_DED = 0;
	localparam int IRQ_SHR = 1;

	// dedicated converter primary/alternate routing
	localparam logic [4:0] DED_PRIMARY_IDX = 5'h00;

	typedef struct packed {
		logic        valid;     // one-cycle strobe
		logic [4:0]  index;     // input index
		logic        alternate; // sampled from dedicated alternate input
		logic        dedicated; // produced by dedicated converter
		logic [11:0] data;      // raw 12-bit result
	} awr_result_t;

	typedef enum logic [1:0] {
		WS_OFF  = 2'b00,
		WS_WARM = 2'b01,
		WS_RDY  = 2'b10
	} awr_wstate_t;

endpackage : awr_pkg

// ===== core/awr_adc_warmup.sv
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
// Behaviour
// - dedicated ready flag sets only after full warm-up count following enable
// - clearing an enable clears its ready flag at once
// - shared enable powers shared analog, warm-up by common count; clear disables
// - dedicated enable powers dedicated analog, waits common count; clear disables
// - control bits six down to one always read zero
// - twenty read-only input presence flags from boot config; upper bits zero
// - top presence flag taken from variant strap in the first cycle after reset release; all flags reset to one
// - 24 read-only 32-bit result registers, zero after reset
// - dedicated alternate-input result lands in the primary input register
// - result reads are formatted by the current fractional format setting
// - delay is 2**code converter clocks, codes below four give sixteen
// - per-converter ready interrupt enable sets irq status when ready sets; interrupt rises only if that status bit's mask bit is set
module awr_adc_warmup
	import awr_pkg::*;
(
	input  wire logic        hclk,           // bus and converter clock
	input  wire logic        hresetn,        // async reset, active low
	input  wire logic        hsel,           // slave select
	input  wire logic [31:0] haddr,          // byte address
	input  wire logic [1:0]  htrans,         // transfer type
	input  wire logic        hwrite,         // write when high
	input  wire logic [2:0]  hsize,          // transfer size
	input  wire logic        hready,         // bus ready in
	input  wire logic [31:0] hwdata,         // write data
	output logic      [31:0] hrdata,         // read data
	output logic             hreadyout,      // slave ready
	output logic             hresp,          // always okay
	input  wire logic        boot_load,      // pulse: load presence config
	input  wire logic [19:0] boot_present,   // presence flags from boot config
	input  wire logic        variant_top,    // variant strap for top flag
	input  wire awr_result_t result_in,      // converter results
	output logic             dedicated_bias_enable, // dedicated analog power
	output logic             shared_bias_enable,    // shared analog power
	output logic             irq             // level interrupt
);

	////////////////////////////////////////////////////////////////////////
	// bus address phase capture
	logic        ap_valid_ff, nxt_ap_valid;
	logic        ap_write_ff, nxt_ap_write;
	logic [7:0]  ap_addr_ff,  nxt_ap_addr;

	always_comb begin
		nxt_ap_valid = 1'b0;
		nxt_ap_write = ap_write_ff;
		nxt_ap_addr  = ap_addr_ff;
		if (hsel && hready && htrans[1]) begin
			nxt_ap_valid = 1'b1;
			nxt_ap_write = hwrite;
			nxt_ap_addr  = haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_valid_ff <= 1'b0;
			ap_write_ff <= 1'b0;
			ap_addr_ff  <= 8'h00;
		end else begin
			ap_valid_ff <= nxt_ap_valid;
			ap_write_ff <= nxt_ap_write;
			ap_addr_ff  <= nxt_ap_addr;
		end
	end

	logic wr_en;
	assign wr_en = ap_valid_ff && ap_write_ff;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a[7:2] == off[7:2]);
	endfunction : hit

	////////////////////////////////////////////////////////////////////////
	// control registers
	logic [3:0] warmup_count_select_ff, nxt_warmup_count_select;
	logic       ded_en_ff, nxt_ded_en;
	logic       shr_en_ff, nxt_shr_en;
	logic       ded_ien_ff, nxt_ded_ien;
	logic       shr_ien_ff, nxt_shr_ien;
	logic       result_format_select_ff, nxt_result_format_select;
	logic [1:0] irq_mask_ff, nxt_irq_mask;

	always_comb begin
		nxt_warmup_count_select  = warmup_count_select_ff;
		nxt_ded_en               = ded_en_ff;
		nxt_shr_en               = shr_en_ff;
		nxt_ded_ien              = ded_ien_ff;
		nxt_shr_ien              = shr_ien_ff;
		nxt_result_format_select = result_format_select_ff;
		nxt_irq_mask             = irq_mask_ff;
		if (wr_en && hit(ap_addr_ff, OFF_WARMUP_CTRL)) begin
			nxt_warmup_count_select = hwdata[CNT_MSB:CNT_LSB];
			nxt_ded_en              = hwdata[BIT_DED_EN];
			nxt_shr_en              = hwdata[BIT_SHR_EN];
			nxt_ded_ien             = hwdata[BIT_DED_IEN];
			nxt_shr_ien             = hwdata[BIT_SHR_IEN];
		end
		if (wr_en && hit(ap_addr_ff, OFF_FORMAT))
			nxt_result_format_select = hwdata[0];
		if (wr_en && hit(ap_addr_ff, OFF_IRQ_MASK))
			nxt_irq_mask = hwdata[1:0];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			warmup_count_select_ff  <= 4'h0;
			ded_en_ff               <= 1'b0;
			shr_en_ff               <= 1'b0;
			ded_ien_ff              <= 1'b0;
			shr_ien_ff              <= 1'b0;
			result_format_select_ff <= 1'b0;
			irq_mask_ff             <= 2'h0;
		end else begin
			warmup_count_select_ff  <= nxt_warmup_count_select;
			ded_en_ff               <= nxt_ded_en;
			shr_en_ff               <= nxt_shr_en;
			ded_ien_ff              <= nxt_ded_ien;
			shr_ien_ff              <= nxt_shr_ien;
			result_format_select_ff <= nxt_result_format_select;
			irq_mask_ff             <= nxt_irq_mask;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// warm-up counters, one per converter
	logic [WCNT_W-1:0] target;
	logic [3:0]        wexp;

	always_comb begin
		wexp   = (warmup_count_select_ff < MIN_EXP) ? MIN_EXP : warmup_count_select_ff;
		target = WCNT_W'(({{(WCNT_W-1){1'b0}}, 1'b1} << wexp) - 1'b1);
	end

	logic [1:0] en_vec;
	logic [1:0] rdy_vec;
	logic [1:0] rdy_rise;
	assign en_vec = {shr_en_ff, ded_en_ff};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_warm
			awr_wstate_t       st_ff, nxt_st;
			logic [WCNT_W-1:0] cnt_ff, nxt_cnt;

			always_comb begin
				nxt_st  = st_ff;
				nxt_cnt = cnt_ff;
				unique case (st_ff)
					WS_OFF: begin
						nxt_cnt = '0;
						if (en_vec[gi])
							nxt_st = WS_WARM;
					end
					WS_WARM: begin
						if (!en_vec[gi]) begin
							nxt_st  = WS_OFF;
							nxt_cnt = '0;
						end else if (cnt_ff >= target) begin
							nxt_st = WS_RDY;
						end else begin
							nxt_cnt = WCNT_W'(cnt_ff + 1'b1);
						end
					end
					WS_RDY: begin
						if (!en_vec[gi]) begin
							nxt_st  = WS_OFF;
							nxt_cnt = '0;
						end
					end
					default: begin
						nxt_st  = WS_OFF;
						nxt_cnt = '0;
					end
				endcase
			end

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					st_ff  <= WS_OFF;
					cnt_ff <= '0;
				end else begin
					st_ff  <= nxt_st;
					cnt_ff <= nxt_cnt;
				end
			end

			// ready reads low in the very cycle its enable drops
			assign rdy_vec[gi]  = (st_ff == WS_RDY) && en_vec[gi];
			assign rdy_rise[gi] = (st_ff == WS_WARM) && (nxt_st == WS_RDY);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// interrupt status: set wins over write-one-to-clear
	logic [1:0] irq_stat_ff, nxt_irq_stat;
	logic [1:0] irq_set;
	logic       irq_ff, nxt_irq;

	always_comb begin
		irq_set      = rdy_rise & {shr_ien_ff, ded_ien_ff};
		nxt_irq_stat = irq_stat_ff;
		if (wr_en && hit(ap_addr_ff, OFF_IRQ_STATUS))
			nxt_irq_stat = irq_stat_ff & ~hwdata[1:0];
		nxt_irq_stat = nxt_irq_stat | irq_set;
		nxt_irq      = |(nxt_irq_stat & irq_mask_ff);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_ff <= 2'h0;
			irq_ff      <= 1'b0;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
			irq_ff      <= nxt_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// input presence flags; top flag caught after reset release
	logic [19:0] present_ff, nxt_present;
	logic        strap_done_ff, nxt_strap_done;

	always_comb begin
		nxt_present    = present_ff;
		nxt_strap_done = 1'b1;
		if (!strap_done_ff)
			nxt_present[NUM_INPUTS-1] = variant_top;
		if (boot_load)
			nxt_present = boot_present;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			present_ff    <= {PRESENT_TOP_DEF, PRESENT_LOW_RST};
			strap_done_ff <= 1'b0;
		end else begin
			present_ff    <= nxt_present;
			strap_done_ff <= nxt_strap_done;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// result storage; raw 12-bit kept, format applied on read
	logic [11:0] result_ff [NUM_RESULTS];
	logic [4:0]  wr_idx;

	always_comb begin
		wr_idx = result_in.index;
		if (result_in.dedicated && result_in.alternate)
			wr_idx = DED_PRIMARY_IDX;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NUM_RESULTS; i++)
				result_ff[i] <= 12'h000;
		end else if (result_in.valid && wr_idx < 5'(NUM_RESULTS)) begin
			result_ff[wr_idx] <= result_in.data;
		end
	end

	// fractional: left-justify into upper bits
	function automatic logic [31:0] fmt(input logic [11:0] raw, input logic frac);
		fmt = frac ? {raw, 20'h00000} : {20'h00000, raw};
	endfunction : fmt

	////////////////////////////////////////////////////////////////////////
	// read mux, registered for the data phase
	logic [31:0] rdata_ff, nxt_rdata;
	logic [7:0]  ridx;

	always_comb begin
		nxt_rdata = RESET_WORD;
		ridx      = 8'(nxt_ap_addr - OFF_RESULT_BASE) >> 2;
		if (nxt_ap_valid && !nxt_ap_write) begin
			if (hit(nxt_ap_addr, OFF_WARMUP_CTRL)) begin
				nxt_rdata[CNT_MSB:CNT_LSB] = warmup_count_select_ff;
				nxt_rdata[BIT_SHR_IEN]     = shr_ien_ff;
				nxt_rdata[BIT_DED_IEN]     = ded_ien_ff;
				nxt_rdata[BIT_SHR_RDY]     = rdy_vec[1];
				nxt_rdata[BIT_DED_RDY]     = rdy_vec[0];
				nxt_rdata[BIT_SHR_EN]      = shr_en_ff;
				nxt_rdata[BIT_DED_EN]      = ded_en_ff;  // bits 6..1 stay zero
			end else if (hit(nxt_ap_addr, OFF_PRESENCE)) begin
				nxt_rdata[19:0] = present_ff;
			end else if (hit(nxt_ap_addr, OFF_FORMAT)) begin
				nxt_rdata[0] = result_format_select_ff;
			end else if (hit(nxt_ap_addr, OFF_IRQ_STATUS)) begin
				nxt_rdata[1:0] = irq_stat_ff;
			end else if (hit(nxt_ap_addr, OFF_IRQ_MASK)) begin
				nxt_rdata[1:0] = irq_mask_ff;
			end else if (nxt_ap_addr >= OFF_RESULT_BASE && ridx < 8'(NUM_RESULTS)) begin
				nxt_rdata = fmt(result_ff[ridx[4:0]], result_format_select_ff);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rdata_ff <= RESET_WORD;
		else
			rdata_ff <= nxt_rdata;
	end

	assign hrdata                = rdata_ff;
	assign hreadyout             = 1'b1;
	assign hresp                 = 1'b0;
	assign dedicated_bias_enable = ded_en_ff;
	assign shared_bias_enable    = shr_en_ff;
	assign irq                   = irq_ff;

endmodule : awr_adc_warmup

// ===== dv/awr_adc_warmup_asserts.sv
`timescale 1ns/1ps
module awr_adc_warmup_asserts
	import awr_pkg::*;
(
	input wire logic        hclk,                  // clock
	input wire logic        hresetn,               // reset
	input wire logic        hsel,                  // select
	input wire logic [31:0] haddr,                 // address
	input wire logic [1:0]  htrans,                // transfer
	input wire logic        hwrite,                // write
	input wire logic        hready,                // ready in
	input wire logic [31:0] hwdata,                // write data
	input wire logic [31:0] hrdata,                // read data
	input wire logic        dedicated_bias_enable, // dedicated power
	input wire logic        shared_bias_enable     // shared power
);
	logic [7:0] on_cnt_ff;
	logic [7:0] nxt_on_cnt;

	// cycles the dedicated enable has been high, saturating
	always_comb begin
		nxt_on_cnt = on_cnt_ff;
		if (!dedicated_bias_enable)
			nxt_on_cnt = 8'h00;
		else if (on_cnt_ff != 8'hff)
			nxt_on_cnt = on_cnt_ff + 8'h01;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			on_cnt_ff <= 8'h00;
		else
			on_cnt_ff <= nxt_on_cnt;
	end

	////////////////////////////////////////////////////////////////
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_acc(logic w, logic [7:0] off);
		hsel && hready && htrans[1] && hwrite == w && haddr[7:0] == off;
	endsequence

	sequence s_wr_ctrl;
		s_acc(1'b1, OFF_WARMUP_CTRL) ##1 1'b1;
	endsequence

	a_ded_en_wr: assert property (s_wr_ctrl |=> dedicated_bias_enable == $past(hwdata[0]))
		else $error("dedicated enable does not follow write");
	a_shr_en_wr: assert property (s_wr_ctrl |=> shared_bias_enable == $past(hwdata[7]))
		else $error("shared enable does not follow write");
	a_ded_en_mirror: assert property (s_acc(1'b0, OFF_WARMUP_CTRL) |=>
		hrdata[BIT_DED_EN] == $past(dedicated_bias_enable)) else $error("dedicated enable bit");
	a_shr_en_mirror: assert property (s_acc(1'b0, OFF_WARMUP_CTRL) |=>
		hrdata[BIT_SHR_EN] == $past(shared_bias_enable)) else $error("shared enable bit");
	a_ctrl_rsvd_zero: assert property (s_acc(1'b0, OFF_WARMUP_CTRL) |=>
		hrdata[6:1] == 6'h00 && hrdata[31:28] == 4'h0) else $error("reserved bits not zero");
	a_pres_upper_zero: assert property (s_acc(1'b0, OFF_PRESENCE) |=>
		hrdata[31:20] == 12'h000) else $error("presence upper bits not zero");
	a_ready_too_soon: assert property (s_acc(1'b0, OFF_WARMUP_CTRL) |=>
		!(hrdata[BIT_DED_RDY] && hrdata[BIT_DED_EN]) || on_cnt_ff >= 8'h11)
		else $error("ready before warm-up count");
	a_ready_needs_en: assert property (s_acc(1'b0, OFF_WARMUP_CTRL) |=>
		!hrdata[BIT_DED_RDY] || (hrdata[BIT_DED_EN] && $past(dedicated_bias_enable, 3)))
		else $error("ready without enable");
endmodule : awr_adc_warmup_asserts

bind awr_adc_warmup awr_adc_warmup_asserts u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hwdata, .hrdata, .dedicated_bias_enable, .shared_bias_enable);

// ===== dv/awr_conv_model.sv
`timescale 1ns/1ps
module awr_conv_model
	import awr_pkg::*;
(
	input  wire logic        hclk,     // clock
	input  wire logic        hresetn,  // reset
	input  wire logic        go,       // emit one result
	input  wire awr_result_t want,     // result to emit
	output awr_result_t      result_in // converter result port
);
	// idle fields toggle so nothing relies on a stale result
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			result_in <= '0;
		else if (go)
			result_in <= {1'b1, want[18:0]};
		else
			result_in <= {1'b0, ~result_in[18:0]};
	end
endmodule : awr_conv_model

// ===== dv/adc_warmup_and_result_regs_tb.sv
`timescale 1ns/1ps
module adc_warmup_and_result_regs_tb;
	import awr_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, boot_load, variant_top;
	logic        ded_en, shr_en, irq, go, alt, ded;
	logic [31:0] haddr, hwdata, hrdata, q, w;
	logic [1:0]  htrans;
	logic [19:0] boot_present;
	logic [4:0]  idx;
	logic [11:0] dat;
	logic [3:0]  codes [4] = '{4'h0, 4'h4, 4'h5, 4'h6};
	awr_result_t result_in, want;
	int          mismatches = 0;
	int          n_compared = 0;
	int          seed = 32428;

	awr_adc_warmup u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .boot_load(boot_load),
		.boot_present(boot_present), .variant_top(variant_top), .result_in(result_in),
		.dedicated_bias_enable(ded_en), .shared_bias_enable(shr_en), .irq(irq));
	awr_conv_model u_conv (.hclk(hclk), .hresetn(hresetn), .go(go), .want(want),
		.result_in(result_in));

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	////////////////////////////////////////////////////////////////
	function automatic int wdelay(input logic [3:0] c);
		return 1 << ((c < MIN_EXP) ? MIN_EXP : c);
	endfunction : wdelay

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic edge_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (hreadyout !== 1'b1) begin
			mismatches++;
			tally_and_finish();
		end
	endtask : edge_rdy

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {24'h000000, a};
		edge_rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		edge_rdy();
		q = hrdata;
	endtask : ahb

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk(nm, q, e);
	endtask : rdc

	////////////////////////////////////////////////////////////////
	initial begin
		{hresetn, hsel, hwrite, boot_load, go} = '0;
		{haddr, hwdata, htrans, boot_present, want} = '0;
		variant_top = 1'($random(seed));
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc("ctrl", OFF_WARMUP_CTRL, 32'h0);
		rdc("present", OFF_PRESENCE, {12'h000, variant_top, PRESENT_LOW_RST});
		for (int i = 0; i < NUM_RESULTS; i++)
			rdc("result", OFF_RESULT_BASE + 8'(4 * i), 32'h0);
		boot_present <= 20'($random(seed));
		boot_load <= 1'b1;
		@(posedge hclk);
		boot_load <= 1'b0;
		ahb(1'b1, OFF_PRESENCE, 32'h0);
		rdc("present", OFF_PRESENCE, {12'h000, boot_present});
		ahb(1'b1, OFF_IRQ_MASK, 32'h3);
		foreach (codes[k]) begin
			w = {4'h0, codes[k], 7'h00, 1'b1, 15'h0000, 1'b1};
			ahb(1'b1, OFF_WARMUP_CTRL, w);
			repeat (wdelay(codes[k])) @(posedge hclk);
			rdc("not ready", OFF_WARMUP_CTRL, w);
			rdc("ready", OFF_WARMUP_CTRL, w | 32'h100);
			repeat (2) @(posedge hclk);
			chk("irq", irq, 32'h1);
			ahb(1'b1, OFF_IRQ_STATUS, 32'h1);
			repeat (2) @(posedge hclk);
			chk("irq clr", irq, 32'h0);
			ahb(1'b1, OFF_WARMUP_CTRL, 32'h0);
			rdc("disabled", OFF_WARMUP_CTRL, 32'h0);
			chk("ded en", ded_en, 32'h0);
		end
		w = {4'h0, 4'(($random(seed) & 3) + 3), 16'h0000, 8'h80};
		ahb(1'b1, OFF_WARMUP_CTRL, w);
		repeat (wdelay(w[27:24]) + 2) @(posedge hclk);
		rdc("shared", OFF_WARMUP_CTRL, w | 32'h8000);
		rdc("status", OFF_IRQ_STATUS, 32'h0);
		chk("shr en", shr_en, 32'h1);
		ahb(1'b1, OFF_WARMUP_CTRL, 32'h0400_0001);
		repeat (10) @(posedge hclk);
		ahb(1'b1, OFF_WARMUP_CTRL, 32'h0);
		ahb(1'b1, OFF_WARMUP_CTRL, 32'h0400_0001);
		repeat (16) @(posedge hclk);
		rdc("restart", OFF_WARMUP_CTRL, 32'h0400_0001);
		rdc("restarted", OFF_WARMUP_CTRL, 32'h0400_0101);
		repeat (8) begin
			idx = 5'(($random(seed) & 32'h7fff_ffff) % NUM_RESULTS);
			{alt, ded, dat} = 14'($random(seed));
			want <= {1'b0, idx, alt, ded, dat};
			go <= 1'b1;
			@(posedge hclk);
			go <= 1'b0;
			@(posedge hclk);
			if (alt && ded)
				idx = DED_PRIMARY_IDX;
			rdc("data", OFF_RESULT_BASE + {1'b0, idx, 2'b00}, {20'h0, dat});
			ahb(1'b1, OFF_FORMAT, 32'h1);
			rdc("result_format_select", OFF_RESULT_BASE + {1'b0, idx, 2'b00}, {dat, 20'h0});
			ahb(1'b1, OFF_FORMAT, 32'h0);
		end
		tally_and_finish();
	end
endmodule : adc_warmup_and_result_regs_tb
